// ### rf_frontend_map.svh
// Purpose: Constants for the RF front-end direct control block
// Assumes: Included by the package and the direct control module by bare name
// Notes: Definitions only; no logic here
`ifndef RF_FRONTEND_MAP_SVH
`define RF_FRONTEND_MAP_SVH

// ==========================================================
// Operation control bit positions
`define RFFE_OPC_RX_EN_BIT 6
`define RFFE_OPC_TX_EN_BIT 3
`define RFFE_OPC_WIDTH 8

// ==========================================================
// Custom Type A frame bits of the Type A settings register
`define RFFE_TYPEA_REG_ADDR 6'h05
`define RFFE_TYPEA_CUSTOM_LO 6
`define RFFE_TYPEA_CUSTOM_HI 7

// ==========================================================
// Stream timing in carrier cycles, and stream and framing field widths in bits
`define RFFE_STX_BASE_CYCLES 8'h80
`define RFFE_STX_WIDTH 3
`define RFFE_FIFO_BYTE_WIDTH 8
`define RFFE_FRAMING_WIDTH 8

// ==========================================================
// Reset values
`define RFFE_RST_BYTE 8'h00
`define RFFE_RST_FRAMING 8'h00

`endif

// ### rf_frontend_pkg.sv
// Purpose: Types shared by the RF front-end direct control block
// Assumes: rf_frontend_map.svh holds the numbers
// Notes: Types only
`include "rf_frontend_map.svh"

package rf_frontend_pkg;

  // ==========================================================
  // Transparent mode sequencing
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_ARMED,
    MODE_TRANSPARENT
  } mode_t;

endpackage

// ### cdc_sync.sv
// Purpose: Two flip-flop level synchroniser, parameterised width
// Assumes: Each bit is a level or a toggle, not a multi-bit word
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps

module cdc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  // ==========================================================
  // Elaboration check
  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("cdc_sync width must be at least one");
    end
  endgenerate

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t cur;
  sync_state_t next_cur;

  // ==========================================================
  // Two stages, second one is the only reader of the first
  always_comb begin
    next_cur = cur;
    next_cur.meta = din;
    next_cur.stable = cur.meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign dout = cur.stable;

endmodule // cdc_sync

// ### rf_frontend_direct_control.sv
// Purpose: Transparent mode pin steering and stream mode bit timing
// Assumes: mclk 100 MHz, rfClk is the carrier-derived link clock
// Notes: Two domains, each with one state struct; handshakes by toggle
//
// Overview of operation
// (RULE_01) Transparent mode starts at slave select rise after its command; holds while high.
// (RULE_02) Host turns on transmitter and receiver and sets analog front end first.
// (RULE_03) In transparent mode MOSI high turns the modulator on, low off.
// (RULE_04) In transparent mode SCLK drives receiver on, enabling strength and gain control.
// (RULE_05) In transparent mode amplitude channel sub-carrier goes to MISO.
// (RULE_06) In transparent mode phase channel sub-carrier goes to the interrupt pin.
// (RULE_07) Receiver channel selection stays effective in transparent mode.
// (RULE_08) Single selected channel goes to MISO; interrupt pin held low.
// (RULE_09) Protocol, framing and FIFO settings ignored in transparent mode; others honoured.
// (RULE_10) Any SPI command ends transparent mode; host re-enters if needed.
// (RULE_11) Host enables carrier only around transmission via operation control writes.
// (RULE_12) Host keeps amplitude channel on for peer replies; phase may be off.
// (RULE_13) Field detect enable turns on external field detector with peer threshold.
// (RULE_14) Field detect enable in transparent mode routes detector to interrupt pin.
// (RULE_15) Field detect enable with operation control all zero gives low-power target.
// (RULE_16) Host wakes oscillator, regulator, receiver after field interrupt, then receives transparently.
// (RULE_17) Field-on commands combine with transparent mode; device interrupts, host sends.
// (RULE_18) Bits 6 and 7 of register 05h enable custom Type A frames.
// (RULE_19) Stream mode chosen by mode setting; options from stream settings; timing internal.
// (RULE_20) Stream receive supports sub-carrier presence and phase-shift keying reporting.
// (RULE_21) First stream bit sent or received sits in the FIFO byte LSB.
// (RULE_22) Host configures receiver and transmitter itself after choosing stream mode.
// (RULE_23) Each stream transmit bit holds one period: zero unmodulated, one modulated.
// (RULE_24) Slave select fall in transparent mode returns pins to SPI decoding.
`timescale 1ns/100ps
`include "rf_frontend_map.svh"

module rf_frontend_direct_control #(
  parameter int STX_WIDTH = `RFFE_STX_WIDTH,
  parameter int FRAMING_WIDTH = `RFFE_FRAMING_WIDTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic rfClk,
  input wire logic ssN,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic amSubcarrier,
  input wire logic pmSubcarrier,
  input wire logic extFieldDetect,
  input wire logic transparentCmd,
  input wire logic spiCmd,
  input wire logic spiMisoData,
  input wire logic spiMisoEnable,
  input wire logic normalIrq,
  input wire logic fieldOnDone,
  input wire logic rxChanAm,
  input wire logic rxChanPm,
  input wire logic field_detect_enable,
  input wire logic [`RFFE_OPC_WIDTH-1:0] opCtrl,
  input wire logic [FRAMING_WIDTH-1:0] framingCfg,
  input wire logic [7:0] typeACfg,
  input wire logic streamModeSel,
  input wire logic streamRxBpsk,
  input wire logic [STX_WIDTH-1:0] stxPeriod,
  input wire logic [7:0] txByte,
  input wire logic txByteValid,
  input wire logic streamRxStrobe,
  input wire logic streamRxData,
  output logic misoOut,
  output logic misoOe,
  output logic irqOut,
  output logic modulatorOn,
  output logic rxOn,
  output logic transparentActive,
  output logic spiDecodeEnable,
  output logic fieldDetectorOn,
  output logic peerThresholdSel,
  output logic lowPowerTarget,
  output logic [FRAMING_WIDTH-1:0] framingCfgEff,
  output logic [1:0] customTypeAFrame,
  output logic streamActive,
  output logic txByteReady,
  output logic [7:0] rxByte,
  output logic rxByteValid,
  output logic streamModOn
);

  // ==========================================================
  // Elaboration checks
  generate
    if (STX_WIDTH < 1 || STX_WIDTH > 3) begin : g_bad_stx
      $error("stream period field must be one to three bits");
    end
    if (FRAMING_WIDTH < 1) begin : g_bad_framing
      $error("framing configuration must be at least one bit");
    end
  endgenerate

  // ==========================================================
  // System clock state
  typedef struct packed {
    rf_frontend_pkg::mode_t mode;
    logic ssPrev;
    logic misoOut;
    logic misoOe;
    logic irqOut;
    logic modulatorOn;
    logic rxOn;
    logic transparentActive;
    logic spiDecodeEnable;
    logic fieldDetectorOn;
    logic peerThresholdSel;
    logic lowPowerTarget;
    logic [FRAMING_WIDTH-1:0] framingCfgEff;
    logic [1:0] customTypeAFrame;
    logic streamActive;
    logic fieldOnIrq;
    logic txReqTgl;
    logic [7:0] txHold;
    logic txBusy;
    logic txByteReady;
    logic ackPrev;
    logic rxTglPrev;
    logic [7:0] rxByte;
    logic rxByteValid;
  } sys_state_t;

  // ==========================================================
  // Link clock state
  typedef struct packed {
    logic reqPrev;
    logic ackTgl;
    logic [7:0] txShift;
    logic [2:0] txBitCnt;
    logic [7:0] periodCnt;
    logic sending;
    logic streamModOn;
    logic [7:0] rxShift;
    logic [2:0] rxBitCnt;
    logic rxTgl;
    logic [7:0] rxOut;
    logic phaseRef;
    logic phaseKnown;
  } link_state_t;

  sys_state_t sys;
  sys_state_t next_sys;
  link_state_t lnk;
  link_state_t next_lnk;

  // ==========================================================
  // Synchronisers
  logic [5:0] pinSync;
  logic [1:0] linkToSys;
  logic [5:0] sysToLink;
  logic ssS;
  logic sclkS;
  logic mosiS;
  logic amS;
  logic pmS;
  logic fieldS;
  logic ackS;
  logic rxTglS;
  logic reqS;
  logic streamS;
  logic bpskS;
  logic [2:0] stxS;

  // Pins come from outside both domains
  cdc_sync #(.WIDTH(6)) u_pin_sync (
    .clk(mclk),
    .rst(rst),
    .din({ssN, sclk, mosi, amSubcarrier, pmSubcarrier, extFieldDetect}),
    .dout(pinSync)
  );

  // Toggles from the link side
  cdc_sync #(.WIDTH(2)) u_link_to_sys (
    .clk(mclk),
    .rst(rst),
    .din({lnk.ackTgl, lnk.rxTgl}),
    .dout(linkToSys)
  );

  // Request toggle and quasi-static stream settings to the link side
  cdc_sync #(.WIDTH(6)) u_sys_to_link (
    .clk(rfClk),
    .rst(rst),
    .din({sys.txReqTgl, sys.streamActive, streamRxBpsk, stxWide(stxPeriod)}),
    .dout(sysToLink)
  );

  assign {ssS, sclkS, mosiS, amS, pmS, fieldS} = pinSync;
  assign ackS = linkToSys[1];
  assign rxTglS = linkToSys[0];
  assign {reqS, streamS, bpskS, stxS} = sysToLink;

  // Widen the stream period field to three bits
  function automatic logic [2:0] stxWide(input logic [STX_WIDTH-1:0] v);
    logic [2:0] w;
    w = '0;
    w[STX_WIDTH-1:0] = v;
    return w;
  endfunction

  // Carrier cycles per transmit bit; longer field values give shorter bits
  function automatic logic [7:0] stxCycles(input logic [2:0] v);
    return `RFFE_STX_BASE_CYCLES >> v;
  endfunction

  // ==========================================================
  // System clock next state
  always_comb begin
    logic inTransp;
    logic ssRise;
    logic ssFall;
    inTransp = 1'b0;
    ssRise = 1'b0;
    ssFall = 1'b0;
    next_sys = sys;
    ssRise = ssS & ~sys.ssPrev;
    ssFall = ~ssS & sys.ssPrev;
    next_sys.ssPrev = ssS;

    // Mode sequencing
    case (sys.mode)
      rf_frontend_pkg::MODE_NORMAL: begin
        if (transparentCmd) begin
          next_sys.mode = rf_frontend_pkg::MODE_ARMED;
        end
      end
      rf_frontend_pkg::MODE_ARMED: begin
        if (spiCmd && !transparentCmd) begin
          next_sys.mode = rf_frontend_pkg::MODE_NORMAL; // RULE_10
        end else if (ssRise) begin
          next_sys.mode = rf_frontend_pkg::MODE_TRANSPARENT; // RULE_01
        end
      end
      rf_frontend_pkg::MODE_TRANSPARENT: begin
        if (ssFall || spiCmd) begin
          next_sys.mode = rf_frontend_pkg::MODE_NORMAL; // RULE_24
        end
      end
      default: begin
        next_sys.mode = rf_frontend_pkg::MODE_NORMAL;
      end
    endcase
    inTransp = (next_sys.mode == rf_frontend_pkg::MODE_TRANSPARENT);
    next_sys.transparentActive = inTransp; // RULE_01
    next_sys.spiDecodeEnable = ~inTransp; // RULE_24

    // Pin steering; channel selects steer MISO and IRQ in transparent mode only
    if (inTransp) begin
      next_sys.modulatorOn = mosiS; // RULE_03
      next_sys.rxOn = sclkS; // RULE_04
      next_sys.misoOe = 1'b1;
      if (rxChanAm && rxChanPm) begin
        next_sys.misoOut = amS; // RULE_05
        next_sys.irqOut = pmS; // RULE_06
      end else begin
        next_sys.misoOut = rxChanAm ? amS : (rxChanPm & pmS); // RULE_07
        next_sys.irqOut = 1'b0; // RULE_08
      end
      if (field_detect_enable) begin
        next_sys.irqOut = fieldS; // RULE_14
      end
    end else begin
      next_sys.modulatorOn = 1'b0;
      next_sys.rxOn = opCtrl[`RFFE_OPC_RX_EN_BIT];
      next_sys.misoOut = spiMisoData;
      next_sys.misoOe = spiMisoEnable;
      next_sys.irqOut = normalIrq | sys.fieldOnIrq; // RULE_17
    end

    // Field-on sequence done: interrupt held until the next command
    if (fieldOnDone) begin
      next_sys.fieldOnIrq = 1'b1; // RULE_17
    end else if (spiCmd) begin
      next_sys.fieldOnIrq = 1'b0;
    end

    // Field detector and low-power target
    next_sys.fieldDetectorOn = field_detect_enable; // RULE_13
    next_sys.peerThresholdSel = field_detect_enable; // RULE_13
    next_sys.lowPowerTarget = field_detect_enable && (opCtrl == '0); // RULE_15

    // Framing and FIFO settings have no meaning in transparent mode
    next_sys.framingCfgEff = inTransp ? '0 : framingCfg; // RULE_09
    next_sys.customTypeAFrame =
      typeACfg[`RFFE_TYPEA_CUSTOM_HI:`RFFE_TYPEA_CUSTOM_LO]; // RULE_18
    next_sys.streamActive = streamModeSel & ~inTransp; // RULE_19

    // Transmit byte handoff; the held byte stays put until acknowledged
    next_sys.ackPrev = ackS;
    if (sys.txBusy && (ackS != sys.ackPrev)) begin
      next_sys.txBusy = 1'b0;
    end
    if (sys.txByteReady && txByteValid && sys.streamActive) begin
      next_sys.txHold = txByte;
      next_sys.txReqTgl = ~sys.txReqTgl;
      next_sys.txBusy = 1'b1;
    end
    next_sys.txByteReady = ~next_sys.txBusy & next_sys.streamActive;

    // Receive byte arrival; link holds the byte for a whole byte time
    next_sys.rxTglPrev = rxTglS;
    next_sys.rxByteValid = 1'b0;
    if (rxTglS != sys.rxTglPrev) begin
      next_sys.rxByte = lnk.rxOut;
      next_sys.rxByteValid = 1'b1;
    end
  end

  // System clock registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sys <= '{mode: rf_frontend_pkg::MODE_NORMAL, ssPrev: 1'b1,
               spiDecodeEnable: 1'b1, framingCfgEff: '0, customTypeAFrame: 2'h0,
               txHold: `RFFE_RST_BYTE, rxByte: `RFFE_RST_BYTE, default: 1'b0};
    end else begin
      sys <= next_sys;
    end
  end

  // ==========================================================
  // Link clock next state: stream bit timing runs on the carrier
  always_comb begin
    logic rxBit;
    rxBit = 1'b0;
    next_lnk = lnk;
    next_lnk.reqPrev = reqS;

    // Transmit: one FIFO bit per period, LSB first
    if (!streamS) begin
      next_lnk.sending = 1'b0;
      next_lnk.streamModOn = 1'b0;
    end else if (lnk.sending) begin
      if (lnk.periodCnt == 8'h01) begin
        if (lnk.txBitCnt == 3'h7) begin
          next_lnk.sending = 1'b0;
          next_lnk.streamModOn = 1'b0;
          next_lnk.ackTgl = ~lnk.ackTgl;
        end else begin
          next_lnk.txShift = {1'b0, lnk.txShift[7:1]}; // RULE_21
          next_lnk.txBitCnt = lnk.txBitCnt + 3'h1;
          next_lnk.periodCnt = stxCycles(stxS);
          next_lnk.streamModOn = lnk.txShift[1]; // RULE_23
        end
      end else begin
        next_lnk.periodCnt = lnk.periodCnt - 8'h01;
      end
    end else if (reqS != lnk.reqPrev) begin
      next_lnk.txShift = sys.txHold;
      next_lnk.txBitCnt = 3'h0;
      next_lnk.periodCnt = stxCycles(stxS); // RULE_19
      next_lnk.sending = 1'b1;
      next_lnk.streamModOn = sys.txHold[0]; // RULE_23
    end

    // Receive: the first reported phase is the reference in phase-keyed mode
    if (!streamS) begin
      next_lnk.phaseKnown = 1'b0;
      next_lnk.rxBitCnt = 3'h0;
    end else if (streamRxStrobe) begin
      if (bpskS) begin
        rxBit = lnk.phaseKnown ? (streamRxData ^ lnk.phaseRef) : 1'b0; // RULE_20
        if (!lnk.phaseKnown) begin
          next_lnk.phaseRef = streamRxData;
          next_lnk.phaseKnown = 1'b1;
        end
      end else begin
        rxBit = streamRxData; // RULE_20
      end
      next_lnk.rxShift = {rxBit, lnk.rxShift[7:1]}; // RULE_21
      next_lnk.rxBitCnt = lnk.rxBitCnt + 3'h1;
      if (lnk.rxBitCnt == 3'h7) begin
        next_lnk.rxOut = {rxBit, lnk.rxShift[7:1]};
        next_lnk.rxTgl = ~lnk.rxTgl;
      end
    end
  end

  // Link clock registers
  always_ff @(posedge rfClk or posedge rst) begin
    if (rst) begin
      lnk <= '0;
    end else begin
      lnk <= next_lnk;
    end
  end

  // ==========================================================
  // Outputs, all straight from flip-flops
  assign misoOut = sys.misoOut;
  assign misoOe = sys.misoOe;
  assign irqOut = sys.irqOut;
  assign modulatorOn = sys.modulatorOn;
  assign rxOn = sys.rxOn;
  assign transparentActive = sys.transparentActive;
  assign spiDecodeEnable = sys.spiDecodeEnable;
  assign fieldDetectorOn = sys.fieldDetectorOn;
  assign peerThresholdSel = sys.peerThresholdSel;
  assign lowPowerTarget = sys.lowPowerTarget;
  assign framingCfgEff = sys.framingCfgEff;
  assign customTypeAFrame = sys.customTypeAFrame;
  assign streamActive = sys.streamActive;
  assign txByteReady = sys.txByteReady;
  assign rxByte = sys.rxByte;
  assign rxByteValid = sys.rxByteValid;
  assign streamModOn = lnk.streamModOn;

endmodule // rf_frontend_direct_control

// ### rf_frontend_direct_control_asserts.sv
// Purpose: Port assertions for the direct control block
// Assumes: Bound into every rf_frontend_direct_control
// Notes: Pin checks wait three quiet edges for the syncs
`timescale 1ns/100ps
module rf_frontend_direct_control_asserts #(
  parameter int FRAMING_WIDTH = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ssN,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic amSubcarrier,
  input wire logic pmSubcarrier,
  input wire logic extFieldDetect,
  input wire logic transparentCmd,
  input wire logic spiCmd,
  input wire logic spiMisoData,
  input wire logic rxChanAm,
  input wire logic rxChanPm,
  input wire logic field_detect_enable,
  input wire logic [7:0] opCtrl,
  input wire logic [7:0] typeACfg,
  input wire logic misoOut,
  input wire logic irqOut,
  input wire logic modulatorOn,
  input wire logic rxOn,
  input wire logic transparentActive,
  input wire logic spiDecodeEnable,
  input wire logic lowPowerTarget,
  input wire logic [FRAMING_WIDTH-1:0] framingCfgEff,
  input wire logic [1:0] customTypeAFrame
);
  // ==========================================================
  // Input history, so async pins are only judged once settled
  logic [23:0] pins;
  logic [71:0] hist;
  logic [1:0] tHist;
  logic [1:0] up;
  logic quiet;
  logic inT;
  logic nrm;
  assign pins = {mosi, sclk, amSubcarrier, pmSubcarrier, extFieldDetect, rxChanAm,
    rxChanPm, field_detect_enable, opCtrl, typeACfg};
  assign quiet = pins == hist[23:0] && pins == hist[47:24] && pins == hist[71:48];
  assign inT = transparentActive && tHist == 2'h3 && quiet;
  assign nrm = !transparentActive && tHist == 2'h0 && up == 2'h3;
  // Three deep history and a settle count after reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hist <= '0;
      tHist <= 2'h0;
      up <= 2'h0;
    end else begin
      hist <= {hist[47:0], pins};
      tHist <= {tHist[0], transparentActive};
      up <= (up == 2'h3) ? up : up + 2'h1;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_decode_mode: assert property (spiDecodeEnable != transparentActive)
    else $error("decode enable not inverse of mode");
  a_enter_ss: assert property ($rose(transparentActive) |-> ssN && $past(ssN))
    else $error("entered without select high");
  a_leave_ss: assert property (!ssN && !$past(ssN) && !$past(ssN, 2) && !$past(ssN, 3)
    |-> !transparentActive) else $error("mode kept with select low");
  a_cmd_exit: assert property (spiCmd && !transparentCmd && transparentActive
    |-> ##[1:2] !transparentActive) else $error("command did not end mode");
  a_mod_follow: assert property (inT |-> modulatorOn == mosi)
    else $error("modulator not following mosi");
  a_rx_follow: assert property (inT |-> rxOn == sclk)
    else $error("receiver not following sclk");
  a_miso_chan: assert property (inT |-> misoOut == (rxChanAm ? amSubcarrier : pmSubcarrier))
    else $error("wrong channel on miso");
  a_irq_chan: assert property (inT |-> irqOut == (field_detect_enable ? extFieldDetect
    : (rxChanAm && rxChanPm && pmSubcarrier))) else $error("wrong level on irq");
  a_framing_off: assert property (transparentActive && tHist == 2'h3
    |-> framingCfgEff == '0) else $error("framing kept in mode");
  a_low_power: assert property (up == 2'h3 && quiet
    |-> lowPowerTarget == (field_detect_enable && opCtrl == 8'h00)) else $error("low power");
  a_typea_bits: assert property (up == 2'h3 && quiet
    |-> customTypeAFrame == typeACfg[7:6]) else $error("custom frame bits");
  a_normal_miso: assert property (nrm |-> misoOut == $past(spiMisoData))
    else $error("miso not back on spi data");
endmodule // rf_frontend_direct_control_asserts

bind rf_frontend_direct_control rf_frontend_direct_control_asserts
  #(.FRAMING_WIDTH(FRAMING_WIDTH)) u_chk (.*);

// ### spi_host_model.sv
// Purpose: Host controller model on the shared SPI pins
// Assumes: Decode pulses stand for whole SPI commands
// Notes: Pins change 1 ns after the mclk rise
`timescale 1ns/100ps
module spi_host_model (
  input wire logic mclk,
  output logic ssN,
  output logic sclk,
  output logic mosi,
  output logic transparentCmd,
  output logic spiCmd,
  output logic [7:0] opCtrl
);
  // ==========================================================
  // Idle: deselected, transmitter and receiver already on
  initial begin
    ssN = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    transparentCmd = 1'b0;
    spiCmd = 1'b0;
    opCtrl = 8'h48;
  end
  // One decoded command, optionally the transparent one
  task pulse(input logic t);
    @(posedge mclk) #1;
    spiCmd = 1'b1;
    transparentCmd = t;
    @(posedge mclk) #1;
    spiCmd = 1'b0;
    transparentCmd = 1'b0;
  endtask
  // Select and write operation control; select is left low
  task cmd(input logic t, input logic [7:0] v);
    @(posedge mclk) #1;
    ssN = 1'b0;
    opCtrl = v;
    repeat (3) @(posedge mclk);
    pulse(t);
    repeat (3) @(posedge mclk);
  endtask
  // Slave select level
  task sel(input logic v);
    @(posedge mclk) #1;
    ssN = v;
  endtask
  // Modulator and receiver control pins
  task pins(input logic m, input logic s);
    @(posedge mclk) #1;
    mosi = m;
    sclk = s;
  endtask
endmodule // spi_host_model

// ### tb.sv
// Purpose: Self-checking bench for the direct control block
// Assumes: spi_host_model drives the shared pins
// Notes: Seeded random pin patterns plus corner cases
`timescale 1ns/100ps
module tb;
  // ==========================================================
  // Stimulus and observed signals
  logic mclk = 1'b0, rfClk = 1'b0, rst = 1'b1;
  logic amSubcarrier = 1'b0, pmSubcarrier = 1'b0, extFieldDetect = 1'b0;
  logic spiMisoData = 1'b0, spiMisoEnable = 1'b0, normalIrq = 1'b0, fieldOnDone = 1'b0;
  logic rxChanAm = 1'b1, rxChanPm = 1'b1, field_detect_enable = 1'b0;
  logic streamModeSel = 1'b0, streamRxBpsk = 1'b0, txByteValid = 1'b0;
  logic streamRxStrobe = 1'b0, streamRxData = 1'b0, rec = 1'b0;
  logic [7:0] framingCfg = 8'h00, typeACfg = 8'h00, txByte = 8'h00, b;
  logic [2:0] stxPeriod = 3'h3;
  logic ssN, sclk, mosi, transparentCmd, spiCmd, misoOut, misoOe, irqOut, modulatorOn;
  logic rxOn, transparentActive, spiDecodeEnable, fieldDetectorOn, peerThresholdSel;
  logic lowPowerTarget, streamActive, txByteReady, rxByteValid, streamModOn;
  logic [7:0] opCtrl, framingCfgEff, rxByte;
  logic [1:0] customTypeAFrame;
  logic modLog[$];
  int err_count = 0, num_checks = 0, n, f;
  // Clocks; the link clock starts 3 ns late, unrelated in phase
  initial forever #5 mclk = ~mclk;
  initial begin
    #3;
    forever #16 rfClk = ~rfClk;
  end
  spi_host_model u_host (.mclk(mclk), .ssN(ssN), .sclk(sclk), .mosi(mosi),
    .transparentCmd(transparentCmd), .spiCmd(spiCmd), .opCtrl(opCtrl));
  rf_frontend_direct_control u_dut (.*);
  // Link side capture of the modulation, one sample per rising edge
  always @(posedge rfClk) if (rec) modLog.push_back(streamModOn);
  // ==========================================================
  // Helpers
  function automatic logic expMiso();
    return rxChanAm ? amSubcarrier : pmSubcarrier;
  endfunction
  function automatic logic expIrq();
    return field_detect_enable ? extFieldDetect : (rxChanAm & rxChanPm & pmSubcarrier);
  endfunction
  function automatic logic [7:0] expBpsk(input logic [7:0] d);
    return d ^ {8{d[0]}};
  endfunction
  task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task tmo(input int k);
    if (k >= 1000) begin
      err_count++;
      $display("mismatch wait expected done seen timeout");
      stop_test();
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task waitMode(input logic v);
    for (n = 0; n < 1000 && transparentActive !== v; n++) cyc(1);
    tmo(n);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(48));
    cyc(7);
    rst = 1'b0;
    cyc(4);
    u_host.sel(1'b0);
    cyc(4);
    u_host.sel(1'b1);
    cyc(6);
    chk(transparentActive, 1'b0, "no cmd");
    u_host.cmd(1'b1, 8'h48);
    cyc(4);
    chk(transparentActive, 1'b0, "armed");
    u_host.sel(1'b1);
    waitMode(1'b1);
    // Random pin patterns, each held long enough to cross the syncs
    for (int i = 0; i < 40; i++) begin
      b = 8'($urandom);
      u_host.pins(b[0], b[1]);
      {amSubcarrier, pmSubcarrier, extFieldDetect} = b[4:2];
      field_detect_enable = b[5] & b[6];
      {rxChanAm, rxChanPm} = 2'($urandom_range(1, 3));
      framingCfg = b;
      streamModeSel = b[7];
      cyc(5);
      chk(modulatorOn, mosi, "mod");
      chk(rxOn, sclk, "rx");
      chk(misoOut, expMiso(), "miso");
      chk(irqOut, expIrq(), "irq");
      chk(framingCfgEff, 8'h00, "framing");
      chk(streamActive, 1'b0, "no stream");
    end
    u_host.sel(1'b0);
    waitMode(1'b0);
    chk(spiDecodeEnable, 1'b1, "decode");
    u_host.cmd(1'b1, 8'h48);
    u_host.sel(1'b1);
    waitMode(1'b1);
    u_host.pulse(1'b0);
    cyc(2);
    chk(transparentActive, 1'b0, "cmd exit");
    // Low power target, then wake and listen transparently
    field_detect_enable = 1'b1;
    u_host.cmd(1'b0, 8'h00);
    u_host.sel(1'b1);
    cyc(5);
    chk(lowPowerTarget, 1'b1, "low power");
    chk({fieldDetectorOn, peerThresholdSel}, 2'h3, "detector");
    u_host.cmd(1'b1, 8'h48);
    cyc(4);
    chk(lowPowerTarget, 1'b0, "awake");
    u_host.sel(1'b1);
    waitMode(1'b1);
    u_host.sel(1'b0);
    waitMode(1'b0);
    field_detect_enable = 1'b0;
    // Field-on completion interrupt until the next command
    {spiMisoData, spiMisoEnable, fieldOnDone} = 3'h7;
    cyc(1);
    fieldOnDone = 1'b0;
    cyc(3);
    chk({irqOut, misoOut, misoOe}, 3'h7, "field on");
    u_host.pulse(1'b0);
    cyc(3);
    chk(irqOut, 1'b0, "irq clear");
    for (int i = 0; i < 4; i++) begin
      typeACfg = i == 0 ? 8'hC0 : 8'($urandom);
      {spiMisoData, spiMisoEnable, normalIrq, framingCfg} = 11'($urandom);
      cyc(2);
      chk(customTypeAFrame, typeACfg[7:6], "type a");
      chk({misoOut, misoOe, irqOut}, {spiMisoData, spiMisoEnable, normalIrq}, "pins");
      chk(framingCfgEff, framingCfg, "framing on");
    end
    // Stream transmit, bit 0 forced high to find the start
    stxPeriod = 3'($urandom_range(3, 7));
    streamModeSel = 1'b1;
    cyc(5);
    chk(streamActive, 1'b1, "stream");
    b = 8'($urandom) | 8'h01;
    for (n = 0; n < 1000 && txByteReady !== 1'b1; n++) cyc(1);
    tmo(n);
    rec = 1'b1;
    txByte = b;
    txByteValid = 1'b1;
    cyc(1);
    txByteValid = 1'b0;
    cyc(2);
    chk(txByteReady, 1'b0, "busy");
    for (n = 0; n < 1000 && txByteReady !== 1'b1; n++) cyc(1);
    tmo(n);
    rec = 1'b0;
    for (f = 0; f < modLog.size() && modLog[f] !== 1'b1; f++);
    for (int i = 0; i < 8; i++)
      chk(modLog[f + (128 >> stxPeriod) * i + (64 >> stxPeriod)], b[i], "tx bit");
    // Stream receive, sub-carrier then phase-shift reporting
    for (int k = 0; k < 2; k++) begin
      streamRxBpsk = k[0];
      b = 8'($urandom);
      repeat (3) @(posedge rfClk);
      for (int i = 0; i < 8; i++) begin
        @(posedge rfClk) #1;
        streamRxStrobe = 1'b1;
        streamRxData = b[i];
        @(posedge rfClk) #1;
        streamRxStrobe = 1'b0;
      end
      for (n = 0; n < 1000 && rxByteValid !== 1'b1; n++) cyc(1);
      tmo(n);
      chk(rxByte, k ? expBpsk(b) : b, "rx byte");
    end
    stop_test();
  end
endmodule // tb
